// ---- verilog/hblank_pattern_defs.svh ----
// Register offsets, field positions and reset values for the blanking pattern block
`ifndef HBLANK_PATTERN_DEFS_SVH
`define HBLANK_PATTERN_DEFS_SVH
`define OFS_P1_AREA0     8'h00
`define OFS_P2_AREA0     8'h06
`define OFS_START_A      8'h0C
`define OFS_START_B      8'h0D
`define OFS_START_C      8'h0E
`define OFS_ODD_AREA0    8'h10
`define OFS_CONFIG       8'h16
`define OFS_STATUS       8'h17
`define OFS_RETIME_WORD  8'h35
`define RETIME_LSB       20
`define RETIME_MSB       23
`define CFG_MODE_BIT     0
`define CFG_THREE_PHASE  1
`define CFG_POL_ODD      2
`define CFG_POL_EVEN     3
`define START_UNUSED     13'h1FFF
`define COUNT_RESET      12'h000
`define ODD_SRC_RESET    3'h0
`define NUM_AREAS        6
`endif

// ---- verilog/hblank_pattern_pkg.sv ----
// Types for the blanking pattern block
package hblank_pattern_pkg;
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_WAIT   = 2'b01,
    ST_PULSE  = 2'b11,
    ST_NEXT   = 2'b10
  } gen_state_e;
endpackage

// ---- verilog/hblank_repeat_area_pattern.sv ----
// Blanking repeat-area pulse pattern generator with register port
//
// Behaviour
// - Phase-one count word: bits 3:0 group A, 7:4 group B, 11:8 group C.
// - Each group count ranges zero to fifteen pulses.
// - Six repeat areas, each with its own 12-bit phase-one count register.
// - Six separate 12-bit phase-two count registers, same layout, independent.
// - Mode one uses counts directly for even lines, selectors for odd lines.
// - Three 13-bit start positions give the pulse group offset in each area.
// - Odd-line area copies the even area chosen by its 3-bit selector.
// - Six odd-line selectors, one per repeat area.
// - Three-phase mode fine-retime field bits 23:20 of word 0x35 adjusts phases.
// - Fine-retime bits for phases one and two restore correct blanking.
// - Retime cleared gives the plain, unshifted blanking on all phases.
// - One polarity bit per phase, shared by all groups, picks high or low mask level for odd and even phases.
// - A zero count suppresses that group in that repeat area.
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "hblank_pattern_defs.svh"
module hblank_repeat_area_pattern
  import hblank_pattern_pkg::*;
#(
  parameter int AREA_LEN = 13'd1024
) (
  input  wire logic        clk_sys,     // Pixel clock, 20 MHz
  input  wire logic        reset,       // Synchronous, active high
  input  wire logic [7:0]  regAddr,     // Register word address
  input  wire logic [23:0] regWdata,    // Write data
  input  wire logic        regWrite,    // Write strobe
  input  wire logic        regRead,     // Read strobe
  output logic      [23:0] regRdata,    // Read data, cycle after strobe
  input  wire logic        blankStart,  // One-cycle start of blanking interval
  input  wire logic        oddLine,     // Current line is odd
  output logic             phaseOneOut, // Odd phase group clock
  output logic             phaseTwoOut, // Even phase group clock
  output logic             windowBusy   // Pattern generation active
);

  localparam logic [12:0] AREA_LEN_C = 13'(AREA_LEN);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [5:0][11:0] p1Count;
    logic [5:0][11:0] p2Count;
    logic [2:0][12:0] startPos;
    logic [5:0][2:0]  oddSource;
    logic [3:0]       cfg;
    logic [3:0]       retime;
    logic [23:0]      rdata;
    gen_state_e       state;
    logic [2:0]       area;
    logic [12:0]      pixel;
    logic [1:0]       group;
    logic [3:0]       left1;
    logic [3:0]       left2;
    logic             lineOdd;
    logic             ph1;
    logic             ph2;
    logic             busy;
  } state_s;

  state_s cur;
  state_s next_cur;

  logic [2:0]  srcArea;
  logic [3:0]  cnt1;
  logic [3:0]  cnt2;
  logic [2:0]  rIdx;
  logic        maskOdd;
  logic        maskEven;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_cur = cur;
    next_cur.rdata = 24'h000000;
    rIdx = 3'(regAddr[2:0]);
    // Odd lines borrow an even area; out-of-range selector falls back to area zero
    srcArea = cur.lineOdd ? cur.oddSource[cur.area] : cur.area;
    if (srcArea > 3'h5) begin
      srcArea = 3'h0;
    end
    cnt1 = cur.p1Count[srcArea][cur.group*4 +: 4];
    cnt2 = cur.p2Count[srcArea][cur.group*4 +: 4];
    maskOdd = cur.cfg[`CFG_POL_ODD];
    maskEven = cur.cfg[`CFG_POL_EVEN];

    if (regWrite) begin
      if (regAddr < `OFS_P2_AREA0) begin
        next_cur.p1Count[rIdx] = regWdata[11:0];
      end else if (regAddr < `OFS_START_A) begin
        next_cur.p2Count[3'(regAddr - `OFS_P2_AREA0)] = regWdata[11:0];
      end else if (regAddr >= `OFS_START_A && regAddr <= `OFS_START_C) begin
        next_cur.startPos[2'(regAddr - `OFS_START_A)] = regWdata[12:0];
      end else if (regAddr >= `OFS_ODD_AREA0 && regAddr < `OFS_CONFIG) begin
        next_cur.oddSource[3'(regAddr - `OFS_ODD_AREA0)] = regWdata[2:0];
      end else if (regAddr == `OFS_CONFIG) begin
        next_cur.cfg = regWdata[3:0];
      end else if (regAddr == `OFS_RETIME_WORD) begin
        next_cur.retime = regWdata[`RETIME_MSB:`RETIME_LSB];
      end
    end
    if (regRead) begin
      if (regAddr < `OFS_P2_AREA0) begin
        next_cur.rdata = {12'h000, cur.p1Count[rIdx]};
      end else if (regAddr < `OFS_START_A) begin
        next_cur.rdata = {12'h000, cur.p2Count[3'(regAddr - `OFS_P2_AREA0)]};
      end else if (regAddr >= `OFS_START_A && regAddr <= `OFS_START_C) begin
        next_cur.rdata = {11'h000, cur.startPos[2'(regAddr - `OFS_START_A)]};
      end else if (regAddr >= `OFS_ODD_AREA0 && regAddr < `OFS_CONFIG) begin
        next_cur.rdata = {21'h000000, cur.oddSource[3'(regAddr - `OFS_ODD_AREA0)]};
      end else if (regAddr == `OFS_CONFIG) begin
        next_cur.rdata = {20'h00000, cur.cfg};
      end else if (regAddr == `OFS_STATUS) begin
        next_cur.rdata = {17'h00000, cur.area, cur.group, cur.state};
      end else if (regAddr == `OFS_RETIME_WORD) begin
        next_cur.rdata = {cur.retime, 20'h00000};
      end
    end

    // Idle level is the programmed mask polarity
    next_cur.ph1 = maskOdd;
    next_cur.ph2 = maskEven;

    case (cur.state)
      ST_IDLE: begin
        next_cur.busy = 1'b0;
        if (blankStart && cur.cfg[`CFG_MODE_BIT]) begin
          next_cur.state = ST_WAIT;
          next_cur.lineOdd = oddLine;
          next_cur.area = 3'h0;
          next_cur.pixel = 13'h0000;
          next_cur.group = 2'h0;
          next_cur.busy = 1'b1;
        end
      end
      ST_WAIT: begin
        next_cur.pixel = cur.pixel + 13'h0001;
        // Unused start of 8191 never matches inside a shorter area
        if (cur.pixel == cur.startPos[cur.group]) begin
          next_cur.left1 = cnt1;
          next_cur.left2 = cnt2;
          if (cnt1 == 4'h0 && cnt2 == 4'h0) begin
            next_cur.state = ST_NEXT;
          end else begin
            next_cur.state = ST_PULSE;
          end
        end else if (cur.pixel == AREA_LEN_C - 13'h0001) begin
          next_cur.state = ST_NEXT;
          next_cur.group = 2'h3;
        end
      end
      ST_PULSE: begin
        next_cur.pixel = cur.pixel + 13'h0001;
        // In three-phase mode a set retime bit holds the phase at its mask level, cancelling the pulse
        if (cur.left1 != 4'h0) begin
          next_cur.ph1 = ~maskOdd ^ (cur.cfg[`CFG_THREE_PHASE] & cur.retime[0]);
          next_cur.left1 = cur.left1 - 4'h1;
        end
        if (cur.left2 != 4'h0) begin
          next_cur.ph2 = ~maskEven ^ (cur.cfg[`CFG_THREE_PHASE] & cur.retime[1]);
          next_cur.left2 = cur.left2 - 4'h1;
        end
        if (cur.left1 <= 4'h1 && cur.left2 <= 4'h1) begin
          next_cur.state = ST_NEXT;
        end
      end
      ST_NEXT: begin
        next_cur.pixel = cur.pixel + 13'h0001;
        if (cur.group < 2'h2) begin
          next_cur.group = cur.group + 2'h1;
          next_cur.state = ST_WAIT;
        end else if (cur.area < 3'(`NUM_AREAS - 1)) begin
          next_cur.area = cur.area + 3'h1;
          next_cur.group = 2'h0;
          next_cur.pixel = 13'h0000;
          next_cur.state = ST_WAIT;
        end else begin
          next_cur.state = ST_IDLE;
          next_cur.busy = 1'b0;
        end
      end
      default: begin
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '0;
      cur.startPos <= {3{`START_UNUSED}};
      cur.ph1 <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  assign regRdata = cur.rdata;
  assign phaseOneOut = cur.ph1;
  assign phaseTwoOut = cur.ph2;
  assign windowBusy = cur.busy;

  // ****************************************
  // Checks
  // ****************************************
  property p_read_word;
    @(posedge clk_sys) disable iff (reset)
      regRead && regAddr == `OFS_CONFIG |=> regRdata == {20'h00000, $past(cur.cfg)};
  endproperty
  a_read_word: assert property (p_read_word) else $error("config readback wrong");

  property p_p1_write;
    @(posedge clk_sys) disable iff (reset)
      regWrite && regAddr == `OFS_P1_AREA0 |=> cur.p1Count[0] == $past(regWdata[11:0]);
  endproperty
  a_p1_write: assert property (p_p1_write) else $error("phase-one count not stored");

  property p_p2_write;
    @(posedge clk_sys) disable iff (reset)
      regWrite && regAddr == `OFS_P2_AREA0 |=> cur.p2Count[0] == $past(regWdata[11:0]);
  endproperty
  a_p2_write: assert property (p_p2_write) else $error("phase-two count not stored");

  property p_mode_gate;
    @(posedge clk_sys) disable iff (reset)
      blankStart && !cur.cfg[`CFG_MODE_BIT] && cur.state == ST_IDLE |=> !windowBusy;
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("started outside mode one");

  property p_start_match;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_WAIT && cur.pixel == cur.startPos[cur.group]
      |=> cur.state != ST_WAIT;
  endproperty
  a_start_match: assert property (p_start_match) else $error("start missed");

  property p_zero_count;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_WAIT && cur.pixel == cur.startPos[cur.group] && cnt1 == 4'h0
      && cnt2 == 4'h0 |=> cur.state == ST_NEXT;
  endproperty
  a_zero_count: assert property (p_zero_count) else $error("zero group not suppressed");

  property p_idle_level;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_IDLE && $past(cur.state) == ST_IDLE && $stable(cur.cfg)
      |-> phaseOneOut == cur.cfg[`CFG_POL_ODD] && phaseTwoOut == cur.cfg[`CFG_POL_EVEN];
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("mask level wrong");

  property p_area_order;
    @(posedge clk_sys) disable iff (reset)
      cur.state != ST_IDLE && $past(cur.state) != ST_IDLE
      |-> cur.area == $past(cur.area) || cur.area == $past(cur.area) + 3'h1;
  endproperty
  a_area_order: assert property (p_area_order) else $error("areas out of order");

  property p_odd_select;
    @(posedge clk_sys) disable iff (reset)
      cur.lineOdd && cur.state == ST_WAIT && cur.oddSource[cur.area] <= 3'h5
      |-> srcArea == cur.oddSource[cur.area];
  endproperty
  a_odd_select: assert property (p_odd_select) else $error("odd selector ignored");

  property p_rdata_idle;
    @(posedge clk_sys) disable iff (reset)
      !regRead |=> regRdata == 24'h000000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not cleared");

  property p_start_write;
    @(posedge clk_sys) disable iff (reset)
      regWrite && regAddr == `OFS_START_C |=> cur.startPos[2] == $past(regWdata[12:0]);
  endproperty
  a_start_write: assert property (p_start_write) else $error("start position not stored");

  property p_odd_write;
    @(posedge clk_sys) disable iff (reset)
      regWrite && regAddr == `OFS_ODD_AREA0 |=> cur.oddSource[0] == $past(regWdata[2:0]);
  endproperty
  a_odd_write: assert property (p_odd_write) else $error("odd selector not stored");

  property p_retime_write;
    @(posedge clk_sys) disable iff (reset)
      regWrite && regAddr == `OFS_RETIME_WORD
      |=> cur.retime == $past(regWdata[`RETIME_MSB:`RETIME_LSB]);
  endproperty
  a_retime_write: assert property (p_retime_write) else $error("retime not stored");

  property p_busy_start;
    @(posedge clk_sys) disable iff (reset)
      blankStart && cur.cfg[`CFG_MODE_BIT] && cur.state == ST_IDLE
      |=> windowBusy && cur.area == 3'h0 && cur.lineOdd == $past(oddLine);
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("window did not start");

  property p_restart_ignored;
    @(posedge clk_sys) disable iff (reset)
      blankStart && cur.state != ST_IDLE |=> $stable(cur.lineOdd);
  endproperty
  a_restart_ignored: assert property (p_restart_ignored) else $error("restart taken");

  // Plain pulse drives the phase away from its mask level
  property p_plain_pulse;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_PULSE && cur.left1 != 4'h0
      && !(cur.cfg[`CFG_THREE_PHASE] && cur.retime[0])
      |=> phaseOneOut != $past(cur.cfg[`CFG_POL_ODD]);
  endproperty
  a_plain_pulse: assert property (p_plain_pulse) else $error("phase-one pulse missing");

  property p_retimed_pulse;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_PULSE && cur.left1 != 4'h0
      && cur.cfg[`CFG_THREE_PHASE] && cur.retime[0]
      |=> phaseOneOut == $past(cur.cfg[`CFG_POL_ODD]);
  endproperty
  a_retimed_pulse: assert property (p_retimed_pulse) else $error("retime not applied");

  property p_phase_two_pulse;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_PULSE && cur.left2 != 4'h0
      && !(cur.cfg[`CFG_THREE_PHASE] && cur.retime[1])
      |=> phaseTwoOut != $past(cur.cfg[`CFG_POL_EVEN]);
  endproperty
  a_phase_two_pulse: assert property (p_phase_two_pulse) else $error("phase-two pulse missing");

  property p_zero_group;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_PULSE && cur.left1 == 4'h0 |=> phaseOneOut == $past(cur.cfg[`CFG_POL_ODD]);
  endproperty
  a_zero_group: assert property (p_zero_group) else $error("spent group still pulsing");

  property p_area_wrap;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_NEXT && cur.group >= 2'h2 && cur.area < 3'h5
      |=> cur.state == ST_WAIT && cur.group == 2'h0 && cur.pixel == 13'h0000;
  endproperty
  a_area_wrap: assert property (p_area_wrap) else $error("next area not entered");

  property p_window_end;
    @(posedge clk_sys) disable iff (reset)
      cur.state == ST_NEXT && cur.group >= 2'h2 && cur.area == 3'h5
      |=> cur.state == ST_IDLE && !windowBusy;
  endproperty
  a_window_end: assert property (p_window_end) else $error("window did not close");

  c_odd_line: cover property (@(posedge clk_sys) blankStart && oddLine && cur.cfg[`CFG_MODE_BIT]);
  c_pulse: cover property (@(posedge clk_sys) cur.state == ST_PULSE);
  c_last_area: cover property (@(posedge clk_sys) cur.area == 3'h5 && cur.state == ST_NEXT);
  c_restart: cover property (@(posedge clk_sys) blankStart && cur.state != ST_IDLE);
  c_retimed: cover property (@(posedge clk_sys) cur.state == ST_PULSE && cur.retime[1:0] != 2'b00);

endmodule
`default_nettype wire

// ---- verification/ccd_hreg_model.sv ----
// Behavioural CCD horizontal register: counts shift cycles in each blanking window
`timescale 1ns/100ps
`default_nettype none
module ccd_hreg_model (
  input  wire logic       clk_sys,    // Pixel clock
  input  wire logic       phaseOne,   // Odd phase group clock
  input  wire logic       phaseTwo,   // Even phase group clock
  input  wire logic       busy,       // Blanking window active
  output logic      [7:0] shiftsOne,  // Active cycles on phase one
  output logic      [7:0] shiftsTwo,  // Active cycles on phase two
  output logic            windowDone  // Window has just closed
);
  logic idleOne = 1'b0;
  logic idleTwo = 1'b0;
  logic busyQ   = 1'b0;
  initial begin
    shiftsOne = 8'h00;
    shiftsTwo = 8'h00;
    windowDone = 1'b0;
  end
  always @(posedge clk_sys) begin
    busyQ <= busy;
    windowDone <= busyQ & ~busy;
    // Counting through busyQ too catches a last pulse landing as busy drops
    if (busy | busyQ) begin
      shiftsOne <= shiftsOne + 8'(phaseOne != idleOne);
      shiftsTwo <= shiftsTwo + 8'(phaseTwo != idleTwo);
    end else begin
      idleOne <= phaseOne;
      idleTwo <= phaseTwo;
      if (windowDone === 1'b1) begin
        shiftsOne <= 8'h00;
        shiftsTwo <= 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/tb.sv ----
// Self-checking bench for the blanking repeat-area pattern generator
`timescale 1ns/100ps
`default_nettype none
`include "hblank_pattern_defs.svh"
module tb;
  // ****************
  // Signals
  // ****************
  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [23:0] regWdata = 24'h000000;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        blankStart = 1'b0;
  logic        oddLine = 1'b0;
  logic        rdPend = 1'b0;
  logic [23:0] regRdata, d;
  logic        phaseOneOut, phaseTwoOut, windowBusy, windowDone;
  logic [7:0]  shiftsOne, shiftsTwo, i;
  logic [11:0] p1[6], p2[6];
  logic [2:0]  sel[6];
  logic [23:0] rdQ[$], cntQ[$];
  int          badCount = 0;
  int          samplesChecked = 0;
  int          seed = 32'hAF42DED9;

  always #25 clk_sys = ~clk_sys;

  // Short areas keep each window near two hundred cycles
  hblank_repeat_area_pattern #(.AREA_LEN(32)) dut (.clk_sys(clk_sys), .reset(reset),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .blankStart(blankStart), .oddLine(oddLine),
    .phaseOneOut(phaseOneOut), .phaseTwoOut(phaseTwoOut), .windowBusy(windowBusy));
  ccd_hreg_model ccd (.clk_sys(clk_sys), .phaseOne(phaseOneOut), .phaseTwo(phaseTwoOut),
    .busy(windowBusy), .shiftsOne(shiftsOne), .shiftsTwo(shiftsTwo), .windowDone(windowDone));

  // ****************
  // Checking
  // ****************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      badCount++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (badCount == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    rdPend <= regRead;
    if (rdPend === 1'b1) check(regRdata, rdQ.pop_front());
    if (windowDone === 1'b1) begin
      check({6'h0, phaseOneOut, phaseTwoOut, shiftsOne, shiftsTwo}, cntQ.pop_front());
    end
  end

  // ****************
  // Drivers
  // ****************
  task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [23:0] wd,
                     input logic [23:0] e);
    regWrite <= w;
    regRead <= r;
    regAddr <= a;
    regWdata <= wd;
    if (r) rdQ.push_back(e);
    @(posedge clk_sys);
  endtask
  task automatic blank(input logic odd, input logic [3:0] cfg, input logic [1:0] rt,
                       input logic noC);
    logic [7:0] e1;
    logic [7:0] e2;
    logic [2:0] s;
    e1 = 8'h00;
    e2 = 8'h00;
    for (int a = 0; a < 6; a++) begin
      s = odd ? sel[a] : 3'(a);
      for (int g = 0; g < 3 - int'(noC); g++) begin
        e1 += 8'(p1[s][4*g+:4]);
        e2 += 8'(p2[s][4*g+:4]);
      end
    end
    if (cfg[1] & rt[0]) e1 = 8'h00;
    if (cfg[1] & rt[1]) e2 = 8'h00;
    cyc(1'b1, 1'b0, `OFS_START_C, noC ? 24'h001FFF : 24'h000014, 24'h0);
    cyc(1'b1, 1'b0, `OFS_RETIME_WORD, {2'b00, rt, 20'h0}, 24'h0);
    cyc(1'b1, 1'b0, `OFS_CONFIG, {20'h0, cfg}, 24'h0);
    cyc(1'b0, 1'b1, `OFS_CONFIG, 24'h0, {20'h0, cfg});
    cyc(1'b0, 1'b1, `OFS_RETIME_WORD, 24'h0, {2'b00, rt, 20'h0});
    blankStart <= 1'b1;
    oddLine <= odd;
    cyc(1'b0, 1'b0, 8'h00, 24'h0, 24'h0);
    blankStart <= 1'b0;
    @(posedge clk_sys);
    check({23'h0, windowBusy}, {23'h0, cfg[0]});
    if (cfg[0]) begin
      cntQ.push_back({6'h0, cfg[2], cfg[3], e1, e2});
      // A restart in mid-window must not disturb the counts
      repeat (20) @(posedge clk_sys);
      blankStart <= 1'b1;
      @(posedge clk_sys);
      blankStart <= 1'b0;
      for (int k = 0; k < 400 && windowDone !== 1'b1; k++) @(posedge clk_sys);
      @(posedge clk_sys);
      check(24'(cntQ.size()), 24'h0);
    end
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (5000) @(posedge clk_sys);
    badCount++;
    summarize();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    for (i = 0; i < 6; i++) begin
      cyc(1'b0, 1'b1, `OFS_P1_AREA0 + i, 24'h0, 24'h0);
      cyc(1'b0, 1'b1, `OFS_P2_AREA0 + i, 24'h0, 24'h0);
      cyc(1'b0, 1'b1, `OFS_ODD_AREA0 + i, 24'h0, 24'h0);
    end
    for (i = 0; i < 3; i++) cyc(1'b0, 1'b1, `OFS_START_A + i, 24'h0, 24'h001FFF);
    cyc(1'b0, 1'b1, `OFS_STATUS, 24'h0, 24'h0);
    for (i = 0; i < 6; i++) begin
      d = 24'($random(seed));
      cyc(1'b1, 1'b0, `OFS_P1_AREA0 + i, d, 24'h0);
      cyc(1'b1, 1'b0, `OFS_P2_AREA0 + i, ~d, 24'h0);
      cyc(1'b0, 1'b1, `OFS_P1_AREA0 + i, 24'h0, {12'h0, d[11:0]});
      cyc(1'b0, 1'b1, `OFS_P2_AREA0 + i, 24'h0, {12'h0, ~d[11:0]});
      // Counts up to seven keep each group clear of the next start
      p1[i] = d[11:0] & 12'h777;
      p2[i] = d[23:12] & 12'h777;
      sel[i] = 3'($unsigned($random(seed)) % 6);
      cyc(1'b1, 1'b0, `OFS_P1_AREA0 + i, {12'h0, p1[i]}, 24'h0);
      cyc(1'b1, 1'b0, `OFS_P2_AREA0 + i, {12'h0, p2[i]}, 24'h0);
      cyc(1'b1, 1'b0, `OFS_ODD_AREA0 + i, {21'h0, sel[i]}, 24'h0);
      cyc(1'b0, 1'b1, `OFS_ODD_AREA0 + i, 24'h0, {21'h0, sel[i]});
    end
    cyc(1'b1, 1'b0, `OFS_START_A, 24'h000001, 24'h0);
    cyc(1'b1, 1'b0, `OFS_START_B, 24'h00000A, 24'h0);
    cyc(1'b1, 1'b0, 8'h20, 24'hFFFFFF, 24'h0);
    cyc(1'b0, 1'b1, 8'h20, 24'h0, 24'h0);
    cyc(1'b0, 1'b1, `OFS_START_B, 24'h0, 24'h00000A);
    blank(1'b0, 4'b0001, 2'b00, 1'b0);
    blank(1'b1, 4'b1101, 2'b00, 1'b0);
    blank(1'b0, 4'b0000, 2'b00, 1'b0);
    blank(1'b1, 4'b0011, 2'b00, 1'b1);
    blank(1'b0, 4'b0011, 2'b01, 1'b0);
    blank(1'b1, 4'b0111, 2'b10, 1'b0);
    summarize();
  end
endmodule
`default_nettype wire
